// [rtl/nvsa_calendar.sv]
// Calendar clock sharing the chip with the backed RAM.
`timescale 1ns/10ps
module nvsa_calendar #(
    parameter int unsigned SEC_CYCLES = nvsa_pkg::SEC_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst,
    output logic [5:0] cal_sec,
    output logic [5:0] cal_min,
    output logic [4:0] cal_hour,
    output logic [4:0] cal_date,
    output logic [3:0] cal_month,
    output logic [2:0] cal_dow,
    output logic [6:0] cal_year
);
    typedef struct packed {
        logic [31:0] div;
        logic [5:0] sec;
        logic [5:0] min;
        logic [4:0] hour;
        logic [4:0] date;
        logic [3:0] month;
        logic [2:0] dow;
        logic [6:0] year;
    } nvsa_cal_t;

    nvsa_cal_t cal_r;
    nvsa_cal_t cal_nxt;

    // Year counts from 2000; the plain divide-by-four test is exact there
    // because 2000 is a leap year and 2100 is out of range.
    function automatic logic [4:0] nvsa_month_days(input logic [3:0] m,
                                                   input logic [6:0] y);
        unique case (m)
            4'h2: return (y[1:0] == 2'h0) ? 5'h1D : 5'h1C;
            4'h4, 4'h6, 4'h9, 4'hB: return 5'h1E;
            default: return 5'h1F;
        endcase
    endfunction

    always_comb
    begin
        cal_nxt = cal_r;
        if (cal_r.div == SEC_CYCLES - 1)
        begin
            cal_nxt.div = '0;
            cal_nxt.sec = cal_r.sec + 6'h01;
            if (cal_r.sec == nvsa_pkg::CAL_SEC_MAX)
            begin
                cal_nxt.sec = 6'h00;
                cal_nxt.min = cal_r.min + 6'h01;
                if (cal_r.min == nvsa_pkg::CAL_SEC_MAX)
                begin
                    cal_nxt.min = 6'h00;
                    cal_nxt.hour = cal_r.hour + 5'h01;
                    if (cal_r.hour == nvsa_pkg::CAL_HOUR_MAX)
                    begin
                        cal_nxt.hour = 5'h00;
                        cal_nxt.dow = (cal_r.dow == nvsa_pkg::CAL_DOW_MAX) ?
                            3'h1 : cal_r.dow + 3'h1;
                        cal_nxt.date = cal_r.date + 5'h01;
                        if (cal_r.date ==
                            nvsa_month_days(cal_r.month, cal_r.year))
                        begin
                            cal_nxt.date = 5'h01;
                            cal_nxt.month = cal_r.month + 4'h1;
                            if (cal_r.month == nvsa_pkg::CAL_MONTH_MAX)
                            begin
                                cal_nxt.month = 4'h1;
                                cal_nxt.year =
                                    (cal_r.year == nvsa_pkg::CAL_YEAR_MAX) ?
                                    7'h00 : cal_r.year + 7'h01;
                            end
                        end
                    end
                end
            end
        end
        else
        begin
            cal_nxt.div = cal_r.div + 32'h1;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            cal_r <= '0;
            cal_r.date <= nvsa_pkg::CAL_DATE_RST;
            cal_r.month <= nvsa_pkg::CAL_MONTH_RST;
            cal_r.dow <= nvsa_pkg::CAL_DOW_RST;
        end
        else
        begin
            cal_r <= cal_nxt;
        end
    end

    assign cal_sec = cal_r.sec;
    assign cal_min = cal_r.min;
    assign cal_hour = cal_r.hour;
    assign cal_date = cal_r.date;
    assign cal_month = cal_r.month;
    assign cal_dow = cal_r.dow;
    assign cal_year = cal_r.year;

    AST_CAL_LEAP: assert property (@(posedge sys_clk) disable iff (rst)
        (cal_month == 4'h2 && cal_date == 5'h1D) |-> cal_year[1:0] == 2'h0)
        else $error("Feb 29 reached in a non-leap year");
    AST_CAL_ROLL: assert property (@(posedge sys_clk) disable iff (rst)
        (cal_r.div == SEC_CYCLES - 1 && cal_sec == 6'h3B) |=>
        cal_sec == 6'h00 && cal_min != $past(cal_min))
        else $error("Seconds did not roll over into minutes");
endmodule // nvsa_calendar

// [rtl/nvsa_pkg.sv]
// Constants and types for the nonvolatile storage access block.
package nvsa_pkg;
    // ------------------------------------------------------------------
    // Flash
    // ------------------------------------------------------------------
    localparam int FL_AW = 19;
    localparam int FL_BYTES = 524288;
    localparam int FL_BLK_AW = 16;
    localparam logic [15:0] FL_OS_SEG = 16'hF000;
    localparam logic [1:0] FL_OP_READ = 2'h0;
    localparam logic [1:0] FL_OP_PROG = 2'h1;
    localparam logic [1:0] FL_OP_ERASE = 2'h2;
    localparam logic [7:0] FL_ERASED = 8'hFF;
    localparam logic [15:0] FL_BLK_LAST = 16'hFFFF;
    // ------------------------------------------------------------------
    // Backed RAM and EEPROM
    // ------------------------------------------------------------------
    localparam int NV_AW = 5;
    localparam logic [4:0] NV_BYTES = 5'h1F;
    localparam int EE_BLK_W = 3;
    localparam int EE_AW = 8;
    localparam int EE_BYTES = 2048;
    localparam logic EE_PROT_RST = 1'b1;
    // ------------------------------------------------------------------
    // Calendar
    // ------------------------------------------------------------------
    localparam int CLK_HZ = 250000000;
    localparam int SEC_S = 1;
    localparam int SEC_CYCLES = CLK_HZ * SEC_S;
    localparam logic [5:0] CAL_SEC_MAX = 6'h3B;
    localparam logic [4:0] CAL_HOUR_MAX = 5'h17;
    localparam logic [3:0] CAL_MONTH_MAX = 4'hC;
    localparam logic [2:0] CAL_DOW_MAX = 3'h7;
    localparam logic [6:0] CAL_YEAR_MAX = 7'h4F;
    localparam logic [4:0] CAL_DATE_RST = 5'h01;
    localparam logic [3:0] CAL_MONTH_RST = 4'h1;
    localparam logic [2:0] CAL_DOW_RST = 3'h1;

    typedef enum logic [0:0] {
        NVSA_FL_IDLE = 1'b0,
        NVSA_FL_ERASE = 1'b1
    } nvsa_fl_state_t;
endpackage

// [rtl/nvsa_top.sv]
// Flash, backed RAM with calendar, and protected EEPROM storage access.
`timescale 1ns/10ps
module nvsa_top #(
    parameter int unsigned SEC_CYCLES = nvsa_pkg::SEC_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic fl_req,
    input wire logic [1:0] fl_op,
    input wire logic [18:0] fl_addr,
    input wire logic [7:0] fl_wdata,
    input wire logic os_unlock,
    output logic [7:0] fl_rdata,
    output logic fl_done,
    output logic fl_refused,
    output logic fl_busy,
    input wire logic nv_req,
    input wire logic nv_we,
    input wire logic [4:0] nv_addr,
    input wire logic [7:0] nv_wdata,
    output logic [7:0] nv_rdata,
    output logic nv_done,
    input wire logic eeprom_unprotect,
    input wire logic eeprom_protect,
    input wire logic ee_req,
    input wire logic ee_we,
    input wire logic [2:0] ee_block,
    input wire logic [7:0] ee_addr,
    input wire logic [7:0] ee_wdata,
    output logic [7:0] ee_rdata,
    output logic ee_done,
    output logic ee_refused,
    output logic ee_protected,
    output logic [5:0] cal_sec,
    output logic [5:0] cal_min,
    output logic [4:0] cal_hour,
    output logic [4:0] cal_date,
    output logic [3:0] cal_month,
    output logic [2:0] cal_dow,
    output logic [6:0] cal_year
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        nvsa_pkg::nvsa_fl_state_t fl_state;
        logic [15:0] erase_cnt;
        logic [2:0] erase_blk;
        logic [7:0] fl_rdata;
        logic fl_done;
        logic fl_refused;
        logic [7:0] nv_rdata;
        logic nv_done;
        logic [7:0] ee_rdata;
        logic ee_done;
        logic ee_refused;
        logic ee_prot;
    } nvsa_state_t;

    nvsa_state_t st_r;
    nvsa_state_t st_nxt;

    // Contents are nonvolatile, so the arrays are never cleared by reset.
    logic [7:0] flash_mem [0:nvsa_pkg::FL_BYTES-1];
    logic [7:0] nv_mem [0:30];
    logic [7:0] ee_mem [0:nvsa_pkg::EE_BYTES-1];

    logic fl_take;
    logic fl_os_hit;
    logic fl_prog_en;
    logic fl_erase_go;
    logic fl_erase_en;
    logic nv_valid;
    logic ee_wr_en;
    logic [10:0] ee_idx;

    // ------------------------------------------------------------------
    // Request decode
    // ------------------------------------------------------------------
    assign fl_take = fl_req && st_r.fl_state == nvsa_pkg::NVSA_FL_IDLE;
    // Reads of the resident segment stay open; only changes are guarded.
    assign fl_os_hit = fl_addr[18:16] == nvsa_pkg::FL_OS_SEG[15:13] &&
                       !os_unlock;
    assign fl_prog_en = fl_take && fl_op == nvsa_pkg::FL_OP_PROG &&
                        !fl_os_hit;
    assign fl_erase_go = fl_take && fl_op == nvsa_pkg::FL_OP_ERASE &&
                         !fl_os_hit;
    assign fl_erase_en = st_r.fl_state == nvsa_pkg::NVSA_FL_ERASE;
    assign nv_valid = nv_addr < nvsa_pkg::NV_BYTES;
    assign ee_wr_en = ee_req && ee_we && !st_r.ee_prot;
    assign ee_idx = {ee_block, ee_addr};

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.fl_done = 1'b0;
        st_nxt.fl_refused = 1'b0;
        st_nxt.nv_done = 1'b0;
        st_nxt.ee_done = 1'b0;
        st_nxt.ee_refused = 1'b0;
        unique case (st_r.fl_state)
            nvsa_pkg::NVSA_FL_IDLE:
            begin
                if (fl_take)
                begin
                    if (fl_op == nvsa_pkg::FL_OP_READ)
                    begin
                        st_nxt.fl_rdata = flash_mem[fl_addr];
                        st_nxt.fl_done = 1'b1;
                    end
                    else if (fl_prog_en)
                    begin
                        st_nxt.fl_done = 1'b1;
                    end
                    else if (fl_erase_go)
                    begin
                        st_nxt.fl_state = nvsa_pkg::NVSA_FL_ERASE;
                        st_nxt.erase_blk = fl_addr[18:16];
                        st_nxt.erase_cnt = 16'h0000;
                    end
                    else
                    begin
                        st_nxt.fl_refused = 1'b1;
                    end
                end
            end
            nvsa_pkg::NVSA_FL_ERASE:
            begin
                st_nxt.erase_cnt = st_r.erase_cnt + 16'h0001;
                if (st_r.erase_cnt == nvsa_pkg::FL_BLK_LAST)
                begin
                    st_nxt.fl_state = nvsa_pkg::NVSA_FL_IDLE;
                    st_nxt.fl_done = 1'b1;
                end
            end
        endcase
        if (nv_req)
        begin
            st_nxt.nv_done = 1'b1;
            st_nxt.nv_rdata = (nv_valid && !nv_we) ?
                nv_mem[nv_addr] : 8'h00;
        end
        if (eeprom_unprotect)
        begin
            st_nxt.ee_prot = 1'b0;
        end
        // Protect wins over a simultaneous unprotect: the safe choice.
        if (eeprom_protect)
        begin
            st_nxt.ee_prot = 1'b1;
        end
        if (ee_req)
        begin
            st_nxt.ee_done = !ee_we || !st_r.ee_prot;
            st_nxt.ee_refused = ee_we && st_r.ee_prot;
            if (!ee_we)
            begin
                st_nxt.ee_rdata = ee_mem[ee_idx];
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            st_r <= '0;
            st_r.ee_prot <= nvsa_pkg::EE_PROT_RST;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Storage arrays
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (fl_prog_en)
        begin
            flash_mem[fl_addr] <= flash_mem[fl_addr] & fl_wdata;
        end
        if (fl_erase_en)
        begin
            flash_mem[{st_r.erase_blk, st_r.erase_cnt}] <=
                nvsa_pkg::FL_ERASED;
        end
        if (nv_req && nv_we && nv_valid)
        begin
            nv_mem[nv_addr] <= nv_wdata;
        end
        if (ee_wr_en)
        begin
            ee_mem[ee_idx] <= ee_wdata;
        end
    end

    nvsa_calendar #(
        .SEC_CYCLES(SEC_CYCLES)
    ) u_calendar (
        .sys_clk(sys_clk),
        .rst(rst),
        .cal_sec(cal_sec),
        .cal_min(cal_min),
        .cal_hour(cal_hour),
        .cal_date(cal_date),
        .cal_month(cal_month),
        .cal_dow(cal_dow),
        .cal_year(cal_year)
    );

    assign fl_rdata = st_r.fl_rdata;
    assign fl_done = st_r.fl_done;
    assign fl_refused = st_r.fl_refused;
    assign fl_busy = fl_erase_en;
    assign nv_rdata = st_r.nv_rdata;
    assign nv_done = st_r.nv_done;
    assign ee_rdata = st_r.ee_rdata;
    assign ee_done = st_r.ee_done;
    assign ee_refused = st_r.ee_refused;
    assign ee_protected = st_r.ee_prot;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    logic [7:0] ast_fl_raw;
    logic [7:0] ast_fl_wd;
    logic [18:0] ast_fl_adr;

    always_ff @(posedge sys_clk)
    begin
        ast_fl_raw <= flash_mem[fl_addr];
        ast_fl_wd <= fl_wdata;
        ast_fl_adr <= fl_addr;
    end

    AST_FL_OS_GUARD: assert property (@(posedge sys_clk) disable iff (rst)
        (fl_take && fl_op != nvsa_pkg::FL_OP_READ && fl_os_hit) |=>
        fl_refused && !fl_busy)
        else $error("Change to resident segment was not refused");
    AST_FL_AND: assert property (@(posedge sys_clk) disable iff (rst)
        fl_prog_en |=> flash_mem[ast_fl_adr] == (ast_fl_raw & ast_fl_wd))
        else $error("Programmed byte is not old AND new");
    AST_FL_ERASE_SPAN: assert property (@(posedge sys_clk) disable iff (rst)
        fl_erase_go |=> fl_busy [*8] ##0 !fl_done)
        else $error("Erase did not hold busy");
    AST_FL_ERASE_END: assert property (@(posedge sys_clk) disable iff (rst)
        (fl_busy && st_r.erase_cnt == 16'hFFFF) |=> fl_done && !fl_busy)
        else $error("Erase did not end after the last byte");
    AST_FL_READ: assert property (@(posedge sys_clk) disable iff (rst)
        (fl_take && fl_op == nvsa_pkg::FL_OP_READ) |=>
        fl_done && fl_rdata == ast_fl_raw)
        else $error("Flash read returned the wrong byte");
    AST_NV_BACK: assert property (@(posedge sys_clk) disable iff (rst)
        (nv_req && nv_we && nv_valid) ##1
        (nv_req && !nv_we && nv_addr == $past(nv_addr)) |=>
        nv_rdata == $past(nv_wdata, 2))
        else $error("Backed RAM did not return the written byte");
    AST_NV_ONE: assert property (@(posedge sys_clk) disable iff (rst)
        nv_req |=> nv_done)
        else $error("Backed RAM access not answered next cycle");
    AST_NV_RANGE: assert property (@(posedge sys_clk) disable iff (rst)
        (nv_req && !nv_valid) |=> nv_rdata == 8'h00)
        else $error("Out-of-range backed RAM read not zero");
    AST_EE_BACK: assert property (@(posedge sys_clk) disable iff (rst)
        (ee_wr_en ##1 (ee_req && !ee_we && ee_idx == $past(ee_idx))) |=>
        ee_rdata == $past(ee_wdata, 2))
        else $error("EEPROM did not return the written byte");
    AST_EE_PROT: assert property (@(posedge sys_clk) disable iff (rst)
        (ee_req && ee_we && ee_protected) |=> ee_refused && !ee_done)
        else $error("Protected EEPROM write was not refused");

    COV_ERASE_DONE: cover property (@(posedge sys_clk) disable iff (rst)
        fl_busy ##1 !fl_busy);
    COV_EE_REFUSED: cover property (@(posedge sys_clk) disable iff (rst)
        ee_refused);
    COV_EE_WRITE: cover property (@(posedge sys_clk) disable iff (rst)
        ee_wr_en ##1 eeprom_protect);
    COV_NV_WRITE: cover property (@(posedge sys_clk) disable iff (rst)
        nv_req && nv_we && nv_valid);
endmodule // nvsa_top

// [tb/nvsa_top_tb.sv]
// Self-checking testbench for the nonvolatile storage access block.
`timescale 1ns/10ps
module nvsa_top_tb;
    localparam int unsigned SEC_CYC = 4;
    logic sys_clk;
    logic rst;
    logic fl_req;
    logic [1:0] fl_op;
    logic [18:0] fl_addr;
    logic [7:0] fl_wdata;
    logic os_unlock;
    logic [7:0] fl_rdata;
    logic fl_done;
    logic fl_refused;
    logic fl_busy;
    logic nv_req;
    logic nv_we;
    logic [4:0] nv_addr;
    logic [7:0] nv_wdata;
    logic [7:0] nv_rdata;
    logic nv_done;
    logic eeprom_unprotect;
    logic eeprom_protect;
    logic ee_req;
    logic ee_we;
    logic [2:0] ee_block;
    logic [7:0] ee_addr;
    logic [7:0] ee_wdata;
    logic [7:0] ee_rdata;
    logic ee_done;
    logic ee_refused;
    logic ee_protected;
    logic [5:0] cal_sec;
    logic [5:0] cal_min;
    logic [4:0] cal_hour;
    logic [4:0] cal_date;
    logic [3:0] cal_month;
    logic [2:0] cal_dow;
    logic [6:0] cal_year;
    int error_cnt;
    int tests_run;

    nvsa_top #(.SEC_CYCLES(SEC_CYC)) dut (.sys_clk(sys_clk), .rst(rst),
        .fl_req(fl_req), .fl_op(fl_op), .fl_addr(fl_addr),
        .fl_wdata(fl_wdata), .os_unlock(os_unlock), .fl_rdata(fl_rdata),
        .fl_done(fl_done), .fl_refused(fl_refused), .fl_busy(fl_busy),
        .nv_req(nv_req), .nv_we(nv_we), .nv_addr(nv_addr),
        .nv_wdata(nv_wdata), .nv_rdata(nv_rdata), .nv_done(nv_done),
        .eeprom_unprotect(eeprom_unprotect),
        .eeprom_protect(eeprom_protect), .ee_req(ee_req), .ee_we(ee_we),
        .ee_block(ee_block), .ee_addr(ee_addr), .ee_wdata(ee_wdata),
        .ee_rdata(ee_rdata), .ee_done(ee_done), .ee_refused(ee_refused),
        .ee_protected(ee_protected), .cal_sec(cal_sec), .cal_min(cal_min),
        .cal_hour(cal_hour), .cal_date(cal_date), .cal_month(cal_month),
        .cal_dow(cal_dow), .cal_year(cal_year));

    initial
    begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    // ------------------------------------------------------------------
    // Shared helpers
    // ------------------------------------------------------------------
    task automatic tally_and_finish();
        $display("checks run %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                       input string msg);
        tests_run++;
        if (got !== exp)
        begin
            $display("mismatch at %0t: %s got %h want %h", $time, msg, got,
                     exp);
            error_cnt++;
        end
    endtask

    // One flash request; the answer pulse is looked at in its own cycle.
    task automatic fl_cmd(input logic [1:0] op, input logic [18:0] a,
                          input logic [7:0] d, input logic refuse);
        @(posedge sys_clk);
        fl_req <= 1'b1;
        fl_op <= op;
        fl_addr <= a;
        fl_wdata <= d;
        @(posedge sys_clk);
        fl_req <= 1'b0;
        #1;
        chk({7'h00, fl_done}, {7'h00, ~refuse}, "flash done");
        chk({7'h00, fl_refused}, {7'h00, refuse}, "flash refused");
    endtask

    task automatic nv_acc(input logic we, input logic [4:0] a,
                          input logic [7:0] d);
        @(posedge sys_clk);
        nv_req <= 1'b1;
        nv_we <= we;
        nv_addr <= a;
        nv_wdata <= d;
        @(posedge sys_clk);
        nv_req <= 1'b0;
        #1;
        chk({7'h00, nv_done}, 8'h01, "backed ram done");
    endtask

    task automatic ee_acc(input logic we, input logic [2:0] b,
                          input logic [7:0] a, input logic [7:0] d,
                          input logic refuse);
        @(posedge sys_clk);
        ee_req <= 1'b1;
        ee_we <= we;
        ee_block <= b;
        ee_addr <= a;
        ee_wdata <= d;
        @(posedge sys_clk);
        ee_req <= 1'b0;
        #1;
        chk({7'h00, ee_done}, {7'h00, ~refuse}, "eeprom done");
        chk({7'h00, ee_refused}, {7'h00, refuse}, "eeprom refused");
    endtask

    task automatic ee_gate(input logic prot);
        @(posedge sys_clk);
        eeprom_protect <= prot;
        eeprom_unprotect <= ~prot;
        @(posedge sys_clk);
        eeprom_protect <= 1'b0;
        eeprom_unprotect <= 1'b0;
        #1;
        chk({7'h00, ee_protected}, {7'h00, prot}, "eeprom protection");
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic scn_reset_state();
        chk({7'h00, ee_protected}, 8'h01, "protected after reset");
        chk({7'h00, fl_busy}, 8'h00, "flash idle after reset");
        chk({3'h0, cal_date}, 8'h01, "date after reset");
        chk({4'h0, cal_month}, 8'h01, "month after reset");
        chk({5'h00, cal_dow}, 8'h01, "weekday after reset");
        chk({1'b0, cal_year}, 8'h00, "year after reset");
    endtask

    // The minute must carry exactly as the second wraps from 59.
    task automatic scn_calendar();
        int n;
        n = 0;
        while (cal_sec !== 6'h3B)
        begin
            @(posedge sys_clk);
            #1;
            n++;
            if (n > 400)
            begin
                error_cnt++;
                tally_and_finish();
            end
        end
        chk({2'h0, cal_min}, 8'h00, "minute before carry");
        repeat (SEC_CYC) @(posedge sys_clk);
        #1;
        chk({2'h0, cal_sec}, 8'h00, "second wraps");
        chk({2'h0, cal_min}, 8'h01, "minute carry");
        chk({3'h0, cal_hour}, 8'h00, "hour unchanged");
    endtask

    task automatic scn_flash();
        int n;
        @(posedge sys_clk);
        fl_req <= 1'b1;
        fl_op <= nvsa_pkg::FL_OP_ERASE;
        fl_addr <= 19'h51234;
        @(posedge sys_clk);
        fl_req <= 1'b0;
        #1;
        n = 0;
        while (fl_done !== 1'b1)
        begin
            chk({7'h00, fl_busy}, 8'h01, "busy during erase");
            @(posedge sys_clk);
            #1;
            n++;
            if (n > 70000)
            begin
                error_cnt++;
                tally_and_finish();
            end
        end
        chk({7'h00, fl_busy}, 8'h00, "busy drops at erase end");
        tests_run++;
        if (n != 65536)
        begin
            $display("mismatch at %0t: erase took %0d cycles", $time, n);
            error_cnt++;
        end
        fl_cmd(nvsa_pkg::FL_OP_READ, 19'h5FFFF, 8'h00, 1'b0);
        chk(fl_rdata, 8'hFF, "erased block end");
        fl_cmd(nvsa_pkg::FL_OP_PROG, 19'h51234, 8'h55, 1'b0);
        fl_cmd(nvsa_pkg::FL_OP_PROG, 19'h51235, 8'hAA, 1'b0);
        fl_cmd(nvsa_pkg::FL_OP_READ, 19'h51234, 8'h00, 1'b0);
        chk(fl_rdata, 8'h55, "low byte read");
        fl_cmd(nvsa_pkg::FL_OP_PROG, 19'h51234, 8'hF0, 1'b0);
        fl_cmd(nvsa_pkg::FL_OP_READ, 19'h51234, 8'h00, 1'b0);
        chk(fl_rdata, 8'h50, "program only clears bits");
        fl_cmd(nvsa_pkg::FL_OP_READ, 19'h51235, 8'h00, 1'b0);
        chk(fl_rdata, 8'hAA, "neighbour byte");
        fl_cmd(2'h3, 19'h51234, 8'h00, 1'b1);
        fl_cmd(nvsa_pkg::FL_OP_PROG, 19'h70000, 8'h00, 1'b1);
        fl_cmd(nvsa_pkg::FL_OP_ERASE, 19'h7ABCD, 8'h00, 1'b1);
        os_unlock <= 1'b1;
        fl_cmd(nvsa_pkg::FL_OP_PROG, 19'h70001, 8'h00, 1'b0);
        os_unlock <= 1'b0;
        // Read back a byte that was written, so the read check sees no
        // unwritten contents.
        fl_cmd(nvsa_pkg::FL_OP_READ, 19'h70001, 8'h00, 1'b0);
        chk(fl_rdata, 8'h00, "resident segment readable");
        fl_cmd(nvsa_pkg::FL_OP_READ, 19'h51234, 8'h00, 1'b0);
        chk(fl_rdata, 8'h50, "refused ops left data alone");
    endtask

    task automatic scn_backed_ram();
        nv_acc(1'b1, 5'h00, 8'h55);
        nv_acc(1'b1, 5'h01, 8'hAA);
        nv_acc(1'b1, 5'h1E, 8'h3C);
        nv_acc(1'b1, 5'h1F, 8'hC3);
        nv_acc(1'b0, 5'h00, 8'h00);
        chk(nv_rdata, 8'h55, "low byte at lower address");
        nv_acc(1'b0, 5'h01, 8'h00);
        chk(nv_rdata, 8'hAA, "high byte at next address");
        nv_acc(1'b0, 5'h1E, 8'h00);
        chk(nv_rdata, 8'h3C, "last implemented byte");
        nv_acc(1'b0, 5'h1F, 8'h00);
        chk(nv_rdata, 8'h00, "unimplemented address reads zero");
        nv_acc(1'b1, 5'h00, 8'h0F);
        nv_acc(1'b0, 5'h00, 8'h00);
        chk(nv_rdata, 8'h0F, "rewrite without erase");
    endtask

    task automatic scn_eeprom();
        ee_acc(1'b1, 3'h1, 8'h0A, 8'h99, 1'b1);
        ee_gate(1'b0);
        ee_acc(1'b1, 3'h1, 8'h0A, 8'h55, 1'b0);
        ee_gate(1'b0);
        ee_acc(1'b1, 3'h1, 8'h0B, 8'hAA, 1'b0);
        ee_acc(1'b1, 3'h7, 8'hFF, 8'h5A, 1'b0);
        ee_acc(1'b1, 3'h0, 8'h0A, 8'h11, 1'b0);
        ee_gate(1'b1);
        ee_acc(1'b1, 3'h1, 8'h0A, 8'h00, 1'b1);
        ee_acc(1'b0, 3'h1, 8'h0A, 8'h00, 1'b0);
        chk(ee_rdata, 8'h55, "byte kept after neighbour write");
        ee_acc(1'b0, 3'h1, 8'h0B, 8'h00, 1'b0);
        chk(ee_rdata, 8'hAA, "neighbour byte");
        ee_acc(1'b0, 3'h7, 8'hFF, 8'h00, 1'b0);
        chk(ee_rdata, 8'h5A, "last block last byte");
        ee_acc(1'b0, 3'h0, 8'h0A, 8'h00, 1'b0);
        chk(ee_rdata, 8'h11, "block number selects block");
    endtask

    // A read right behind a write to the same byte must see the new data.
    task automatic scn_back_to_back();
        ee_gate(1'b0);
        @(posedge sys_clk);
        nv_req <= 1'b1;
        nv_we <= 1'b1;
        nv_addr <= 5'h05;
        nv_wdata <= 8'hC6;
        ee_req <= 1'b1;
        ee_we <= 1'b1;
        ee_block <= 3'h2;
        ee_addr <= 8'h33;
        ee_wdata <= 8'h6C;
        @(posedge sys_clk);
        nv_we <= 1'b0;
        ee_we <= 1'b0;
        @(posedge sys_clk);
        nv_req <= 1'b0;
        ee_req <= 1'b0;
        #1;
        chk(nv_rdata, 8'hC6, "backed ram write then read");
        chk(ee_rdata, 8'h6C, "eeprom write then read");
        ee_gate(1'b1);
    endtask

    initial
    begin
        error_cnt = 0;
        tests_run = 0;
        rst = 1'b1;
        fl_req = 1'b0;
        fl_op = 2'h0;
        fl_addr = 19'h00000;
        fl_wdata = 8'h00;
        os_unlock = 1'b0;
        nv_req = 1'b0;
        nv_we = 1'b0;
        nv_addr = 5'h00;
        nv_wdata = 8'h00;
        eeprom_unprotect = 1'b0;
        eeprom_protect = 1'b0;
        ee_req = 1'b0;
        ee_we = 1'b0;
        ee_block = 3'h0;
        ee_addr = 8'h00;
        ee_wdata = 8'h00;
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        #1;
        scn_reset_state();
        scn_calendar();
        scn_backed_ram();
        scn_eeprom();
        scn_back_to_back();
        scn_flash();
        tally_and_finish();
    end
endmodule // nvsa_top_tb
